// File: pmic_interrupt_flags.sv
`default_nettype none
// How it works
// - Power-good pin falling from active to inactive sets top bit 7.
// - Top bit 6 reads 1 while any linear regulator flag is pending.
// - Top bit 6 drops by itself once the linear flag register is zero.
// - Top bit 5 summarises the buck flag register, clearing when it is zero.
// - Sync clock appearing or disappearing sets top bit 4.
// - Thermal shutdown sets bit 3, turns regulators off, drives outputs low.
// - While the thermal shutdown flag is set no regulator may be enabled.
// - Thermal warning sets top bit 2 and shuts nothing down.
// - Input over-voltage sets bit 1, turns regulators off, drives outputs low.
// - A new load-current result sets top bit 0.
// - Supply undervoltage or software reset sets reset flag, restores defaults, restarts.
// - Buck power-good events set buck bits 6 and 2.
// - Buck short held longer than 1 ms sets buck bits 5 and 1.
// - Buck current limit activity sets buck bits 4 and 0.
// - Flags reset to zero; writing 1 clears, writing 0 leaves them.
// - Linear flag register mirrors buck layout and clearing.
module pmic_interrupt_flags
	import pmic_flags_pkg::*;
#(
	parameter int SHORT_LIMIT_CYCLES = pmic_flags_pkg::SHORT_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port behind the serial interface
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Monitored conditions
	input wire logic power_good_pin_i,
	input wire logic sync_clk_present_i,
	input wire logic thermal_shutdown_live_i,
	input wire logic thermal_warning_live_i,
	input wire logic overvoltage_live_i,
	input wire logic load_meas_done_i,
	input wire logic analog_supply_low_i,
	input wire logic software_reset_bit_i,
	// Per regulator: 0 buck0, 1 buck1, 2 linear0, 3 linear1
	input wire logic [REGULATOR_COUNT-1:0] conv_power_good_event_i,
	input wire logic [REGULATOR_COUNT-1:0] conv_below_short_i,
	input wire logic [REGULATOR_COUNT-1:0] conv_current_limit_i,
	// Enables requested by the rest of the device, and their gated results
	input wire logic [REGULATOR_COUNT-1:0] regulator_en_req_i,
	input wire logic general_output_a_req_i,
	input wire logic general_output_b_req_i,
	output logic [REGULATOR_COUNT-1:0] regulator_en_o,
	output logic general_output_a_o,
	output logic general_output_b_o,
	output logic restart_o
);
	import pmic_flags_pkg::*;

	function automatic logic rise(input logic now, input logic was);
		return now & ~was;
	endfunction

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	// ******************************
	// Condition history
	// ******************************
	logic armed_reg;
	logic pg_prev_reg;
	logic sync_prev_reg;
	logic tsd_prev_reg;
	logic warn_prev_reg;
	logic ovp_prev_reg;
	logic uv_prev_reg;

	// History is meaningless in the first cycle after reset, hence the arm bit
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			armed_reg <= 1'b0;
			pg_prev_reg <= 1'b0;
			sync_prev_reg <= 1'b0;
			tsd_prev_reg <= 1'b0;
			warn_prev_reg <= 1'b0;
			ovp_prev_reg <= 1'b0;
			uv_prev_reg <= 1'b0;
		end else begin
			armed_reg <= 1'b1;
			pg_prev_reg <= power_good_pin_i;
			sync_prev_reg <= sync_clk_present_i;
			tsd_prev_reg <= thermal_shutdown_live_i;
			warn_prev_reg <= thermal_warning_live_i;
			ovp_prev_reg <= overvoltage_live_i;
			uv_prev_reg <= analog_supply_low_i;
		end
	end

	// ******************************
	// Event detection
	// ******************************
	wire power_good_lost_evt = armed_reg && rise(pg_prev_reg, power_good_pin_i);
	wire sync_change_evt = armed_reg && (sync_clk_present_i != sync_prev_reg);
	wire thermal_shutdown_evt = rise(thermal_shutdown_live_i, tsd_prev_reg);
	wire thermal_warning_evt = rise(thermal_warning_live_i, warn_prev_reg);
	wire overvoltage_evt = rise(overvoltage_live_i, ovp_prev_reg);
	wire supply_low_evt = rise(analog_supply_low_i, uv_prev_reg);
	wire restart_evt = supply_low_evt || software_reset_bit_i;

	// ******************************
	// Address decode
	// ******************************
	// Writes and reads share one decode so they always agree on the map
	wire top_sel = addr_hit(reg_addr_i, TOP_FLAGS_ADDR);
	wire reset_sel = addr_hit(reg_addr_i, RESET_FLAGS_ADDR);
	wire buck_sel = addr_hit(reg_addr_i, BUCK_FLAGS_ADDR);
	wire linear_sel = addr_hit(reg_addr_i, LINEAR_FLAGS_ADDR);

	// ******************************
	// Register writes
	// ******************************
	wire top_wr = reg_wr_i && top_sel;
	wire reset_wr = reg_wr_i && reset_sel;
	wire buck_wr = reg_wr_i && buck_sel;
	wire linear_wr = reg_wr_i && linear_sel;
	// Ones clear, zeros and read-only or reserved bits are left alone
	wire [7:0] top_clear = top_wr ? (reg_wdata_i & TOP_W1C_MASK) : 8'h00;
	wire [7:0] reset_clear = reset_wr ? (reg_wdata_i & RESET_W1C_MASK) : 8'h00;
	wire [7:0] buck_clear = buck_wr ? (reg_wdata_i & CONV_W1C_MASK) : 8'h00;
	wire [7:0] linear_clear = linear_wr ? (reg_wdata_i & CONV_W1C_MASK) : 8'h00;

	// ******************************
	// Per-regulator events
	// ******************************
	logic [3*REGULATOR_COUNT-1:0] conv_events;

	genvar n;
	generate
		for (n = 0; n < REGULATOR_COUNT; n++) begin : gen_conv
			logic short_long;
			short_filter #(
				.LIMIT(SHORT_TIMER_WIDTH'(SHORT_LIMIT_CYCLES))
			) u_short (
				.mclk_i(mclk_i),
				.rst_i(rst_i),
				.below_i(conv_below_short_i[n]),
				.long_o(short_long)
			);
			assign conv_events[3*n+POWER_GOOD_BIT] = conv_power_good_event_i[n];
			assign conv_events[3*n+SHORT_BIT] = short_long;
			assign conv_events[3*n+CURRENT_LIMIT_BIT] = conv_current_limit_i[n];
		end
	endgenerate

	// Bits 7 and 3 stay reserved in both regulator registers
	wire [7:0] buck_set = {1'b0, conv_events[5:3], 1'b0, conv_events[2:0]};
	wire [7:0] linear_set = {1'b0, conv_events[11:9], 1'b0, conv_events[8:6]};

	// ******************************
	// Flag banks
	// ******************************
	logic [7:0] top_latched;
	logic [7:0] reset_flags;
	logic [7:0] buck_flags;
	logic [7:0] linear_flags;
	logic [7:0] top_set;

	always_comb begin
		top_set = 8'h00;
		top_set[POWER_GOOD_LOST_BIT] = power_good_lost_evt;
		top_set[SYNC_CLOCK_BIT] = sync_change_evt;
		top_set[THERMAL_SHUTDOWN_BIT] = thermal_shutdown_evt;
		top_set[THERMAL_WARNING_BIT] = thermal_warning_evt;
		top_set[INPUT_OVERVOLTAGE_BIT] = overvoltage_evt;
		top_set[LOAD_MEAS_DONE_BIT] = load_meas_done_i;
	end

	// A restart wipes the other banks but itself leaves the reset flag set
	event_flags u_top (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.restore_i(restart_evt),
		.set_i(top_set),
		.clear_i(top_clear),
		.flags_o(top_latched)
	);
	event_flags u_reset (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.restore_i(1'b0),
		.set_i({7'h00, restart_evt}),
		.clear_i(reset_clear),
		.flags_o(reset_flags)
	);
	event_flags u_buck (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.restore_i(restart_evt),
		.set_i(buck_set),
		.clear_i(buck_clear),
		.flags_o(buck_flags)
	);
	event_flags u_linear (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.restore_i(restart_evt),
		.set_i(linear_set),
		.clear_i(linear_clear),
		.flags_o(linear_flags)
	);

	// ******************************
	// Summary bits
	// ******************************
	// Summaries are pure functions of the banks, so they fall with the last clear
	wire linear_pending = |linear_flags;
	wire buck_pending = |buck_flags;
	wire [7:0] top_view = {top_latched[7], linear_pending, buck_pending, top_latched[4:0]};

	// ******************************
	// Shutdown hold
	// ******************************
	logic shutdown_hold_reg;

	// Hold lasts until every regulator enable request is withdrawn; a level request
	// left high would otherwise re-enable straight into the fault
	wire shutdown_hold_next = thermal_shutdown_evt || overvoltage_evt || restart_evt ||
		(shutdown_hold_reg && (|regulator_en_req_i));
	wire enable_blocked = shutdown_hold_next || top_latched[THERMAL_SHUTDOWN_BIT];

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			shutdown_hold_reg <= 1'b0;
		end else begin
			shutdown_hold_reg <= shutdown_hold_next;
		end
	end

	// ******************************
	// Restart pulse
	// ******************************
	logic restart_reg;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= restart_evt;
		end
	end

	// ******************************
	// Regulator and output gating
	// ******************************
	logic [REGULATOR_COUNT-1:0] regulator_en_reg;
	logic [REGULATOR_COUNT-1:0] regulator_en_next;
	logic general_output_a_reg;
	logic general_output_b_reg;

	genvar r;
	generate
		for (r = 0; r < REGULATOR_COUNT; r++) begin : gen_gate
			assign regulator_en_next[r] = regulator_en_req_i[r] && !enable_blocked;
		end
	endgenerate
	wire general_output_a_next = general_output_a_req_i && !shutdown_hold_next;
	wire general_output_b_next = general_output_b_req_i && !shutdown_hold_next;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			regulator_en_reg <= '0;
			general_output_a_reg <= 1'b0;
			general_output_b_reg <= 1'b0;
		end else begin
			regulator_en_reg <= regulator_en_next;
			general_output_a_reg <= general_output_a_next;
			general_output_b_reg <= general_output_b_next;
		end
	end

	assign regulator_en_o = regulator_en_reg;
	assign general_output_a_o = general_output_a_reg;
	assign general_output_b_o = general_output_b_reg;
	assign restart_o = restart_reg;

	// ******************************
	// Register reads
	// ******************************
	logic [7:0] rdata_reg;
	// Reading only samples; no flag is touched by it
	wire [7:0] read_select = top_sel ? top_view :
		reset_sel ? reset_flags :
		buck_sel ? buck_flags :
		linear_sel ? linear_flags : UNMAPPED_READ_VALUE;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd_i) begin
			rdata_reg <= read_select;
		end
	end

	assign reg_rdata_o = rdata_reg;
endmodule
`default_nettype wire

// File: pmic_flags_pkg.sv
`default_nettype none
package pmic_flags_pkg;
	// ******************************
	// Register map
	// ******************************
	localparam logic [7:0] TOP_FLAGS_ADDR = 8'h19;
	localparam logic [7:0] RESET_FLAGS_ADDR = 8'h1a;
	localparam logic [7:0] BUCK_FLAGS_ADDR = 8'h1b;
	localparam logic [7:0] LINEAR_FLAGS_ADDR = 8'h1c;
	localparam logic [7:0] FLAG_RESET_VALUE = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// ******************************
	// Top flag register fields
	// ******************************
	localparam int POWER_GOOD_LOST_BIT = 7;
	localparam int LINEAR_SUMMARY_BIT = 6;
	localparam int BUCK_SUMMARY_BIT = 5;
	localparam int SYNC_CLOCK_BIT = 4;
	localparam int THERMAL_SHUTDOWN_BIT = 3;
	localparam int THERMAL_WARNING_BIT = 2;
	localparam int INPUT_OVERVOLTAGE_BIT = 1;
	localparam int LOAD_MEAS_DONE_BIT = 0;
	localparam logic [7:0] TOP_W1C_MASK = 8'h9f;

	// ******************************
	// Reset flag register fields
	// ******************************
	localparam int RESET_EVENT_BIT = 0;
	localparam logic [7:0] RESET_W1C_MASK = 8'h01;

	// ******************************
	// Per-regulator flag fields (buck and linear alike)
	// ******************************
	localparam int CONV1_FIELD_BASE = 4;
	localparam int POWER_GOOD_BIT = 2;
	localparam int SHORT_BIT = 1;
	localparam int CURRENT_LIMIT_BIT = 0;
	localparam logic [7:0] CONV_W1C_MASK = 8'h77;
	localparam int REGULATOR_COUNT = 4;

	// ******************************
	// Timing
	// ******************************
	localparam int CLOCK_FREQ_KHZ = 100000;
	localparam int SHORT_TIME_MS = 1;
	localparam int SHORT_CYCLES = SHORT_TIME_MS * CLOCK_FREQ_KHZ;
	localparam int SHORT_TIMER_WIDTH = 17;
endpackage
`default_nettype wire

// File: short_filter.sv
`default_nettype none
module short_filter
	import pmic_flags_pkg::*;
#(
	parameter logic [SHORT_TIMER_WIDTH-1:0] LIMIT = SHORT_TIMER_WIDTH'(SHORT_CYCLES)
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Comparator level and qualified result
	input wire logic below_i,
	output logic long_o
);
	logic [SHORT_TIMER_WIDTH-1:0] count_reg;
	logic [SHORT_TIMER_WIDTH-1:0] count_next;

	// Saturates so a lasting short keeps reporting instead of wrapping
	assign count_next = !below_i ? '0 :
		(count_reg == LIMIT) ? count_reg : count_reg + 1'b1;
	assign long_o = below_i && (count_reg == LIMIT);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end
endmodule
`default_nettype wire

// File: event_flags.sv
`default_nettype none
module event_flags
	import pmic_flags_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register defaults restore
	input wire logic restore_i,
	// Events and clears
	input wire logic [7:0] set_i,
	input wire logic [7:0] clear_i,
	output logic [7:0] flags_o
);
	logic [7:0] flags_reg;
	logic [7:0] flags_next;

	// Set wins over clear and over restore, so no event is dropped
	assign flags_next = set_i | (restore_i ? FLAG_RESET_VALUE : (flags_reg & ~clear_i));
	assign flags_o = flags_reg;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			flags_reg <= FLAG_RESET_VALUE;
		end else begin
			flags_reg <= flags_next;
		end
	end
endmodule
`default_nettype wire

// File: pmic_interrupt_flags_props.sv
`default_nettype none
module pmic_interrupt_flags_props
	import pmic_flags_pkg::*;
#(
	parameter int SHORT_LIMIT_CYCLES = 20
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Conditions
	input wire logic thermal_shutdown_live_i,
	input wire logic overvoltage_live_i,
	input wire logic software_reset_bit_i,
	// Gated outputs
	input wire logic [REGULATOR_COUNT-1:0] regulator_en_req_i,
	input wire logic [REGULATOR_COUNT-1:0] regulator_en_o,
	input wire logic general_output_a_o,
	input wire logic general_output_b_o,
	input wire logic restart_o
);
	// ***
	// Checks
	// ***
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	tsd_off_a: assert property ($rose(thermal_shutdown_live_i) |=> regulator_en_o == 4'h0
		&& !general_output_a_o && !general_output_b_o) else $error("on after shutdown");
	ovp_off_a: assert property ($rose(overvoltage_live_i) |=> regulator_en_o == 4'h0
		&& !general_output_a_o && !general_output_b_o) else $error("on after overvoltage");
	reset_off_a: assert property (software_reset_bit_i |=> regulator_en_o == 4'h0)
		else $error("on after reset event");
	restart_pulse_a: assert property (software_reset_bit_i |=> restart_o)
		else $error("no restart");
	// Enables may only follow a request, never invent one
	en_gate_a: assert property (regulator_en_o != 4'h0 |->
		(regulator_en_o & ~$past(regulator_en_req_i)) == 4'h0) else $error("unrequested enable");
	rd_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
	unmapped_rd_a: assert property (reg_rd_i && (reg_addr_i < TOP_FLAGS_ADDR ||
		reg_addr_i > LINEAR_FLAGS_ADDR) |=> reg_rdata_o == UNMAPPED_READ_VALUE)
		else $error("unmapped read");
	buck_resv_a: assert property (reg_rd_i && reg_addr_i == BUCK_FLAGS_ADDR |=>
		(reg_rdata_o & ~CONV_W1C_MASK) == 8'h00) else $error("buck reserved set");
	rst_resv_a: assert property (reg_rd_i && reg_addr_i == RESET_FLAGS_ADDR |=>
		reg_rdata_o[7:1] == 7'h00) else $error("reset reserved set");
	cover property ($rose(thermal_shutdown_live_i));
	cover property (restart_o);
	cover property (reg_rd_i && reg_addr_i == BUCK_FLAGS_ADDR);
endmodule
bind pmic_interrupt_flags pmic_interrupt_flags_props #(
	.SHORT_LIMIT_CYCLES(SHORT_LIMIT_CYCLES)
) props (
	.mclk_i(mclk_i),
	.rst_i(rst_i),
	.reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.thermal_shutdown_live_i(thermal_shutdown_live_i),
	.overvoltage_live_i(overvoltage_live_i),
	.software_reset_bit_i(software_reset_bit_i),
	.regulator_en_req_i(regulator_en_req_i),
	.regulator_en_o(regulator_en_o),
	.general_output_a_o(general_output_a_o),
	.general_output_b_o(general_output_b_o),
	.restart_o(restart_o)
);
`default_nettype wire

// File: host_model.sv
`default_nettype none
module host_model (
	// Clock
	input wire logic mclk_i,
	// Register port
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		wdata_o = 8'h00;
		rd_o = 1'b0;
	end
	// Released lines show the inverse so stale values are never trusted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge mclk_i);
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// File: pmic_interrupt_flags_test.sv
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module pmic_interrupt_flags_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pmic_flags_pkg::*;
	localparam int LIM = 20;
	logic mclk_i, rst_i, tsd, ovp, uv, swr, ga, gb, rd, wr, goa, gob, restart;
	logic [11:0] ev;
	logic [3:0] below, req, en;
	logic [7:0] addr, wdata, rdata, got;
	int failures = 0;
	int tests_run = 0;
	// Event mask, address, flag value, top value
	logic [35:0] rows [12] = '{36'h001_19_04_04, 36'h002_19_01_01, 36'h004_19_10_10,
		36'h008_19_80_80, 36'h010_1b_04_20, 36'h020_1b_40_20, 36'h040_1c_04_40,
		36'h080_1c_40_40, 36'h100_1b_01_20, 36'h200_1b_10_20, 36'h400_1c_01_40,
		36'h800_1c_10_40};
	pmic_interrupt_flags #(.SHORT_LIMIT_CYCLES(LIM)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .power_good_pin_i(~ev[3]), .sync_clk_present_i(ev[2]),
		.thermal_shutdown_live_i(tsd), .thermal_warning_live_i(ev[0]),
		.overvoltage_live_i(ovp), .load_meas_done_i(ev[1]), .analog_supply_low_i(uv),
		.software_reset_bit_i(swr), .conv_power_good_event_i(ev[7:4]),
		.conv_below_short_i(below), .conv_current_limit_i(ev[11:8]),
		.regulator_en_req_i(req), .general_output_a_req_i(ga),
		.general_output_b_req_i(gb), .regulator_en_o(en), .general_output_a_o(goa),
		.general_output_b_o(gob), .restart_o(restart));
	host_model host (.mclk_i(mclk_i), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
		.rd_o(rd), .rdata_i(rdata));
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, got);
		`CHK(got, e)
	endtask
	task automatic fire(input logic [11:0] m);
		@(posedge mclk_i);
		ev <= m;
		@(posedge mclk_i);
		ev <= 12'h000;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		failures++;
		end_of_test();
	end
	initial begin
		{rst_i, tsd, ovp, uv, swr, ga, gb, ev, below, req} = {1'b1, 26'h0};
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		for (int a = 8'h19; a <= 8'h1d; a++) rdc(8'(a), 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			fire(rows[i][35:24]);
			rdc(rows[i][23:16], rows[i][15:8]);
			rdc(8'h19, rows[i][7:0]);
			host.wr(rows[i][23:16], 8'h00);
			rdc(rows[i][23:16], rows[i][15:8]);
			host.wr(rows[i][23:16], 8'hff);
			rdc(rows[i][23:16], 8'h00);
			rdc(8'h19, 8'h00);
			$display("row %0d done", i);
		end
		// A clear that meets a still active limit loses to it
		@(posedge mclk_i) ev <= 12'h100;
		host.wr(BUCK_FLAGS_ADDR, 8'h01);
		rdc(BUCK_FLAGS_ADDR, 8'h01);
		@(posedge mclk_i) ev <= 12'h000;
		host.wr(BUCK_FLAGS_ADDR, 8'h01);
		rdc(BUCK_FLAGS_ADDR, 8'h00);
		$display("level test done");
		// A short held for exactly the limit must not latch
		@(posedge mclk_i) below <= 4'h1;
		repeat (LIM) @(posedge mclk_i);
		below <= 4'ha;
		repeat (LIM + 3) @(posedge mclk_i);
		below <= 4'h0;
		rdc(BUCK_FLAGS_ADDR, 8'h20);
		rdc(LINEAR_FLAGS_ADDR, 8'h20);
		rdc(TOP_FLAGS_ADDR, 8'h60);
		host.wr(BUCK_FLAGS_ADDR, 8'hff);
		host.wr(LINEAR_FLAGS_ADDR, 8'hff);
		$display("short test done");
		@(posedge mclk_i) {req, ga, gb} <= 6'h3f;
		fire(12'h001);
		repeat (3) @(posedge mclk_i);
		#1 `CHK({en, goa, gob}, 6'h3f)
		host.wr(TOP_FLAGS_ADDR, 8'h04);
		@(posedge mclk_i) tsd <= 1'b1;
		repeat (3) @(posedge mclk_i);
		#1 `CHK({en, goa, gob}, 6'h00)
		@(posedge mclk_i) tsd <= 1'b0;
		// Withdrawing the requests ends the hold, so only the flag still blocks
		@(posedge mclk_i) req <= 4'h0;
		@(posedge mclk_i) req <= 4'hf;
		repeat (5) @(posedge mclk_i);
		#1 `CHK(en, 4'h0)
		rdc(TOP_FLAGS_ADDR, 8'h08);
		host.wr(TOP_FLAGS_ADDR, 8'h08);
		repeat (3) @(posedge mclk_i);
		#1 `CHK(en, 4'hf)
		@(posedge mclk_i) ovp <= 1'b1;
		repeat (3) @(posedge mclk_i);
		#1 `CHK({en, goa, gob}, 6'h00)
		@(posedge mclk_i) ovp <= 1'b0;
		rdc(TOP_FLAGS_ADDR, 8'h02);
		host.wr(TOP_FLAGS_ADDR, 8'h02);
		rdc(TOP_FLAGS_ADDR, 8'h00);
		$display("shutdown test done");
		fire(12'h001);
		@(posedge mclk_i) swr <= 1'b1;
		@(posedge mclk_i) swr <= 1'b0;
		#1 `CHK(restart, 1'b1)
		rdc(RESET_FLAGS_ADDR, 8'h01);
		rdc(TOP_FLAGS_ADDR, 8'h00);
		host.wr(RESET_FLAGS_ADDR, 8'h00);
		rdc(RESET_FLAGS_ADDR, 8'h01);
		host.wr(RESET_FLAGS_ADDR, 8'h01);
		rdc(RESET_FLAGS_ADDR, 8'h00);
		@(posedge mclk_i) uv <= 1'b1;
		@(posedge mclk_i) uv <= 1'b0;
		rdc(RESET_FLAGS_ADDR, 8'h01);
		$display("reset event test done");
		fire(12'h001);
		@(posedge mclk_i) rst_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		#1 `CHK({en, goa, gob, restart, rdata}, 15'h0000)
		@(posedge mclk_i) rst_i <= 1'b0;
		rdc(RESET_FLAGS_ADDR, 8'h00);
		rdc(TOP_FLAGS_ADDR, 8'h00);
		$display("mid reset test done");
		end_of_test();
	end
endmodule
`default_nettype wire
